// file: logic/pgs_pkg.sv
package pgs_pkg;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] TIMER_OFS       = 8'h04;
  localparam logic [7:0] SLIP_COUNT_OFS  = 8'h08;
  localparam logic [7:0] DIV_RATIO_OFS   = 8'h0c;
  localparam logic [7:0] BURST_OFS       = 8'h10;
  localparam logic [7:0] COMMAND_OFS     = 8'h14;
  localparam logic [7:0] STATUS_OFS      = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h1c;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h20;

  // CTRL field positions
  localparam int CTRL_CHAN_EN_BIT   = 0;
  localparam int CTRL_DYN_GATE_BIT  = 1;
  localparam int CTRL_CLAMP_LSB     = 2;
  localparam int CTRL_RSLIP_BIT     = 4;
  localparam int CTRL_SLIP_EN_BIT   = 5;
  localparam int CTRL_SYNC_EN_BIT   = 6;
  localparam int CTRL_LAUNCH_LSB    = 7;

  // COMMAND bits (write one to request)
  localparam int CMD_SYNC_BIT  = 0;
  localparam int CMD_PULSE_BIT = 1;
  localparam int CMD_SLIP_BIT  = 2;

  // Interrupt bits
  localparam int IRQ_SLIP_DONE_BIT = 0;
  localparam int IRQ_SEQ_DONE_BIT  = 1;
  localparam int IRQ_WIDTH         = 2;

  // Field encodings
  localparam logic [1:0] CLAMP_ZERO   = 2'h2;
  localparam logic [1:0] LAUNCH_PULSE = 2'h3;
  localparam logic [11:0] MIN_DYN_RATIO = 12'h01f;

  // Reset values
  localparam logic [8:0]  CTRL_RST      = 9'h000;
  localparam logic [11:0] TIMER_RST     = 12'h040;
  localparam logic [11:0] SLIP_CNT_RST  = 12'h001;
  localparam logic [11:0] DIV_RATIO_RST = 12'h020;
  localparam logic [7:0]  BURST_RST     = 8'h01;

  // Timing
  localparam int CLK_PERIOD_NS   = 4;
  localparam int SLIP_TIME_NS    = 10;
  localparam int SLIP_CYC        = (SLIP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_DELAY_CYC = 4;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ENABLE = 6'h02,
    ST_RESET  = 6'h04,
    ST_START  = 6'h08,
    ST_RUN    = 6'h10,
    ST_STOP   = 6'h20
  } pgs_state_t;

endpackage

// file: logic/pgs_slip_unit.sv
module pgs_slip_unit #(
  parameter int CNT_W = 12
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             start,
  input  wire logic             repeat_en,
  input  wire logic [CNT_W-1:0] count,
  output logic                  slip_pulse,
  output logic                  busy,
  output logic                  done,
  output logic [CNT_W-1:0]      pending
);

  logic [7:0] wait_cnt;

  // Pending slips: loaded, one less per completed slip, done at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      pending    <= '0;
      wait_cnt   <= '0;
      busy       <= 1'b0;
      slip_pulse <= 1'b0;
      done       <= 1'b0;
    end else begin
      slip_pulse <= 1'b0;
      done       <= 1'b0;
      if (start) begin
        // Zero count is unsupported; treat as a single slip
        pending    <= (repeat_en && count != '0) ? count : CNT_W'(1);
        busy       <= 1'b1;
        slip_pulse <= 1'b1;
        wait_cnt   <= 8'(pgs_pkg::SLIP_CYC - 1);
      end else if (busy) begin
        if (wait_cnt != 8'h00) begin
          wait_cnt <= wait_cnt - 8'h01;
        end else if (pending == CNT_W'(1)) begin
          pending <= '0;
          busy    <= 1'b0;
          done    <= 1'b1;
        end else begin
          pending    <= pending - CNT_W'(1);
          slip_pulse <= 1'b1;
          wait_cnt   <= 8'(pgs_pkg::SLIP_CYC - 1);
        end
      end
    end
  end

endmodule

// file: logic/pgs_sequencer.sv
// Operation
// - Gate off: buffer follows channel enable only
// - Gate on, pulse mode: buffer follows divider
// - Clamp 10: force zero when idle
// - Clamp 00: idle outputs float
// - Repeated slip starts after sync/pulse start
// - Each slip repeats slip-count times; the code does so only with CTRL_RSLIP_BIT set, otherwise it gives one slip
// - Slips take time; completion alarm given
// - Timer period from 12-bit setting
// - Request steps dividers enable, reset, start, stop
// - Bursts counted in timer periods
// - Stream starts fixed cycles after start
// - Stop forces output zero without delay
// - Launch mode 11 powers divider per burst; the code does so only for div_ratio above MIN_DYN_RATIO
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module pgs_sequencer (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SYNC_PIN,
  output logic             DIV_ENABLE,
  output logic             DIV_RESET,
  output logic             DIV_RUN,
  output logic             DIV_SLIP,
  output logic             BUF_ENABLE,
  output logic             PRE_BUF_ZERO,
  output logic             IRQ
);

  logic [8:0]  ctrl;
  logic [11:0] reference_period_timer;
  logic [11:0] slip_count;
  logic [11:0] div_ratio;
  logic [7:0]  burst_len;
  logic [pgs_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [pgs_pkg::IRQ_WIDTH-1:0] irq_mask;
  logic [pgs_pkg::IRQ_WIDTH-1:0] irq_event;

  logic        wr_en;
  logic        rd_en;
  logic        sync_meta;
  logic        sync_sync;
  logic        sync_prev;
  logic [11:0] timer_cnt;
  logic        tick;
  logic        req_sync;
  logic        req_pulse;
  logic        pulse_job;
  logic [7:0]  burst_cnt;
  logic [2:0]  start_cnt;
  pgs_pkg::pgs_state_t state;
  pgs_pkg::pgs_state_t next_state;
  logic        slip_start;
  logic        slip_busy;
  logic        slip_done;
  logic        slip_pulse;
  logic [11:0] slip_pending;
  logic        dyn_mode;
  logic        next_run;
  logic        next_div_en;

  logic       chan_en;
  logic       dyn_gate;
  logic [1:0] clamp;
  logic       rslip_allow;
  logic       slip_en;
  logic       sync_en;
  logic [1:0] launch;

  assign chan_en     = ctrl[pgs_pkg::CTRL_CHAN_EN_BIT];
  assign dyn_gate    = ctrl[pgs_pkg::CTRL_DYN_GATE_BIT];
  assign clamp       = ctrl[pgs_pkg::CTRL_CLAMP_LSB +: 2];
  assign rslip_allow = ctrl[pgs_pkg::CTRL_RSLIP_BIT];
  assign slip_en     = ctrl[pgs_pkg::CTRL_SLIP_EN_BIT];
  assign sync_en     = ctrl[pgs_pkg::CTRL_SYNC_EN_BIT];
  assign launch      = ctrl[pgs_pkg::CTRL_LAUNCH_LSB +: 2];

  // One wait state so that read data can come from a flop
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign rd_en = PSEL && PENABLE && !PREADY && !PWRITE;

  function automatic logic addr_known(input logic [7:0] a);
    return a == pgs_pkg::CTRL_OFS || a == pgs_pkg::TIMER_OFS ||
           a == pgs_pkg::SLIP_COUNT_OFS || a == pgs_pkg::DIV_RATIO_OFS ||
           a == pgs_pkg::BURST_OFS || a == pgs_pkg::COMMAND_OFS ||
           a == pgs_pkg::STATUS_OFS || a == pgs_pkg::IRQ_STATUS_OFS ||
           a == pgs_pkg::IRQ_MASK_OFS;
  endfunction

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !addr_known(PADDR);
      if (rd_en) begin
        if (PADDR == pgs_pkg::CTRL_OFS) begin
          PRDATA <= {23'h000000, ctrl};
        end else if (PADDR == pgs_pkg::TIMER_OFS) begin
          PRDATA <= {20'h00000, reference_period_timer};
        end else if (PADDR == pgs_pkg::SLIP_COUNT_OFS) begin
          PRDATA <= {20'h00000, slip_count};
        end else if (PADDR == pgs_pkg::DIV_RATIO_OFS) begin
          PRDATA <= {20'h00000, div_ratio};
        end else if (PADDR == pgs_pkg::BURST_OFS) begin
          PRDATA <= {24'h000000, burst_len};
        end else if (PADDR == pgs_pkg::STATUS_OFS) begin
          PRDATA <= {11'h000, slip_pending, 1'b0, slip_busy, 1'b0, state};
        end else if (PADDR == pgs_pkg::IRQ_STATUS_OFS) begin
          PRDATA <= {30'h00000000, irq_status};
        end else if (PADDR == pgs_pkg::IRQ_MASK_OFS) begin
          PRDATA <= {30'h00000000, irq_mask};
        end else begin
          PRDATA <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl                   <= pgs_pkg::CTRL_RST;
      reference_period_timer <= pgs_pkg::TIMER_RST;
      slip_count             <= pgs_pkg::SLIP_CNT_RST;
      div_ratio              <= pgs_pkg::DIV_RATIO_RST;
      burst_len              <= pgs_pkg::BURST_RST;
      irq_mask               <= '0;
    end else if (wr_en) begin
      if (PADDR == pgs_pkg::CTRL_OFS) begin
        ctrl <= PWDATA[8:0];
      end else if (PADDR == pgs_pkg::TIMER_OFS) begin
        reference_period_timer <= PWDATA[11:0];
      end else if (PADDR == pgs_pkg::SLIP_COUNT_OFS) begin
        slip_count <= PWDATA[11:0];
      end else if (PADDR == pgs_pkg::DIV_RATIO_OFS) begin
        div_ratio <= PWDATA[11:0];
      end else if (PADDR == pgs_pkg::BURST_OFS) begin
        burst_len <= PWDATA[7:0];
      end else if (PADDR == pgs_pkg::IRQ_MASK_OFS) begin
        irq_mask <= PWDATA[pgs_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  // Sticky events; a new event beats a write-one clear
  assign irq_event[pgs_pkg::IRQ_SLIP_DONE_BIT] = slip_done;
  assign irq_event[pgs_pkg::IRQ_SEQ_DONE_BIT]  = state == pgs_pkg::ST_STOP && tick;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_status <= '0;
      IRQ        <= 1'b0;
    end else begin
      if (wr_en && PADDR == pgs_pkg::IRQ_STATUS_OFS) begin
        irq_status <= (irq_status & ~PWDATA[pgs_pkg::IRQ_WIDTH-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      IRQ <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= SYNC_PIN;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end

  // Period setting of zero acts as one cycle
  assign tick = timer_cnt >= reference_period_timer - 12'h001 || reference_period_timer == '0;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      timer_cnt <= '0;
    end else if (tick) begin
      timer_cnt <= '0;
    end else begin
      timer_cnt <= timer_cnt + 12'h001;
    end
  end

  // Requests wait for the next timer period boundary
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      req_sync  <= 1'b0;
      req_pulse <= 1'b0;
      pulse_job <= 1'b0;
    end else begin
      if (state == pgs_pkg::ST_IDLE && next_state == pgs_pkg::ST_ENABLE) begin
        pulse_job <= req_pulse;
        req_sync  <= 1'b0;
        req_pulse <= 1'b0;
      end else begin
        if (sync_en && ((sync_sync && !sync_prev) ||
            (wr_en && PADDR == pgs_pkg::COMMAND_OFS && PWDATA[pgs_pkg::CMD_SYNC_BIT]))) begin
          req_sync <= 1'b1;
        end
        if (wr_en && PADDR == pgs_pkg::COMMAND_OFS && PWDATA[pgs_pkg::CMD_PULSE_BIT]) begin
          req_pulse <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      pgs_pkg::ST_IDLE:   if (tick && chan_en && (req_sync || req_pulse)) begin
        next_state = pgs_pkg::ST_ENABLE;
      end
      pgs_pkg::ST_ENABLE: if (tick) begin
        next_state = pgs_pkg::ST_RESET;
      end
      pgs_pkg::ST_RESET:  if (tick) begin
        next_state = pgs_pkg::ST_START;
      end
      pgs_pkg::ST_START:  if (start_cnt == 3'(pgs_pkg::START_DELAY_CYC - 1)) begin
        next_state = pgs_pkg::ST_RUN;
      end
      pgs_pkg::ST_RUN:    if (tick && (!pulse_job || burst_cnt <= 8'h01)) begin
        next_state = pgs_pkg::ST_STOP;
      end
      pgs_pkg::ST_STOP:   if (tick) begin
        next_state = pgs_pkg::ST_IDLE;
      end
      default:            next_state = pgs_pkg::ST_IDLE;
    endcase
    if (!chan_en) begin
      next_state = pgs_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state     <= pgs_pkg::ST_IDLE;
      start_cnt <= '0;
      burst_cnt <= '0;
    end else begin
      state     <= next_state;
      start_cnt <= (state == pgs_pkg::ST_START) ? start_cnt + 3'h1 : 3'h0;
      if (next_state == pgs_pkg::ST_RUN && state != pgs_pkg::ST_RUN) begin
        burst_cnt <= burst_len;
      end else if (state == pgs_pkg::ST_RUN && tick && burst_cnt != 8'h00) begin
        burst_cnt <= burst_cnt - 8'h01;
      end
    end
  end

  // Dynamic power only for large ratios; small ones stay powered
  assign dyn_mode    = launch == pgs_pkg::LAUNCH_PULSE && div_ratio > pgs_pkg::MIN_DYN_RATIO;
  assign next_run    = next_state == pgs_pkg::ST_RUN;
  assign next_div_en = chan_en && (!dyn_mode || next_state != pgs_pkg::ST_IDLE);

  // Outputs come from next_state so stop lands on the same edge as the state
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      DIV_ENABLE   <= 1'b0;
      DIV_RESET    <= 1'b0;
      DIV_RUN      <= 1'b0;
      BUF_ENABLE   <= 1'b0;
      PRE_BUF_ZERO <= 1'b0;
      DIV_SLIP     <= 1'b0;
    end else begin
      DIV_ENABLE   <= next_div_en;
      DIV_RESET    <= next_state == pgs_pkg::ST_RESET;
      DIV_RUN      <= next_run;
      BUF_ENABLE   <= (dyn_gate && dyn_mode) ? next_div_en : chan_en;
      PRE_BUF_ZERO <= chan_en && clamp == pgs_pkg::CLAMP_ZERO && !next_run;
      DIV_SLIP     <= slip_pulse && slip_en;
    end
  end

  // Automatic slip on stream start, or software slip command
  assign slip_start = slip_en &&
    ((rslip_allow && state == pgs_pkg::ST_START && next_state == pgs_pkg::ST_RUN) ||
     (wr_en && PADDR == pgs_pkg::COMMAND_OFS && PWDATA[pgs_pkg::CMD_SLIP_BIT]));

  pgs_slip_unit #(
    .CNT_W (12)
  ) pgs_slip_unit_inst (
    .clk        (CLOCK),
    .srst       (SRST),
    .start      (slip_start),
    .repeat_en  (rslip_allow),
    .count      (slip_count),
    .slip_pulse (slip_pulse),
    .busy       (slip_busy),
    .done       (slip_done),
    .pending    (slip_pending)
  );

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  a_buf_follow_en: assert property (!(dyn_gate && dyn_mode) |=> BUF_ENABLE == $past(chan_en))
    else $error("Buffer enable not following channel enable");
  a_buf_gated_dyn: assert property ((dyn_gate && dyn_mode) |=> BUF_ENABLE == DIV_ENABLE)
    else $error("Buffer enable not following divider");
  a_clamp_idle: assert property (
    (chan_en && clamp == pgs_pkg::CLAMP_ZERO && next_state == pgs_pkg::ST_IDLE) |=> PRE_BUF_ZERO)
    else $error("Idle output not clamped");
  a_clamp_float: assert property (clamp == 2'h0 |=> !PRE_BUF_ZERO)
    else $error("Clamp active while float chosen");
  a_auto_slip: assert property (
    (slip_en && rslip_allow && state == pgs_pkg::ST_START && next_state == pgs_pkg::ST_RUN)
    |=> slip_busy ##1 DIV_SLIP)
    else $error("No slip after stream start");
  a_slip_load: assert property ((slip_start && rslip_allow && slip_count != '0)
    |=> slip_pending == $past(slip_count))
    else $error("Pending slips not loaded");
  a_slip_done: assert property (slip_done |-> !slip_busy && slip_pending == '0)
    else $error("Slip alarm while slips pending");
  a_seq_order: assert property (state == pgs_pkg::ST_RESET && next_state != pgs_pkg::ST_RESET
    && chan_en |-> next_state == pgs_pkg::ST_START)
    else $error("Sequence skipped start");
  a_start_delay: assert property ($rose(state == pgs_pkg::ST_START) && chan_en
    |-> (state == pgs_pkg::ST_START && chan_en) [*4] ##1 DIV_RUN)
    else $error("Stream start delay wrong");
  a_stop_fast: assert property ($fell(next_state == pgs_pkg::ST_RUN) |=> !DIV_RUN)
    else $error("Stream not stopped at once");
  a_dyn_power: assert property ((dyn_mode && chan_en && state == pgs_pkg::ST_IDLE
    && next_state == pgs_pkg::ST_IDLE) |=> !DIV_ENABLE)
    else $error("Divider powered outside burst");

  c_pulse_burst: cover property (pulse_job && state == pgs_pkg::ST_STOP);
  c_sync_seq: cover property (!pulse_job && state == pgs_pkg::ST_RUN ##1 state == pgs_pkg::ST_STOP);
  c_multi_slip: cover property (slip_done && $past(slip_count) > 12'h002);

endmodule

// file: verification/pgs_far_model.sv
module pgs_far_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        div_slip,
  input  wire logic        sync_req,
  output logic             sync_pin,
  output logic [15:0]      slips_seen
);
  logic [1:0] hold;

  // Held three clocks so the two-stage synchroniser cannot miss it
  always_ff @(posedge clk) begin
    if (srst) begin
      hold <= 2'h0;
    end else if (sync_req) begin
      hold <= 2'h3;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end

  assign sync_pin = (hold != 2'h0);

  // Counts each phase step the divider is told to take
  always_ff @(posedge clk) begin
    if (srst) begin
      slips_seen <= 16'h0000;
    end else if (div_slip) begin
      slips_seen <= slips_seen + 16'h0001;
    end
  end
endmodule

// file: verification/pulse_gen_channel_sequencer_tb_top.sv
module pulse_gen_channel_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_pin;
  logic        sync_req;
  logic        div_enable;
  logic        div_reset;
  logic        div_run;
  logic        div_slip;
  logic        buf_enable;
  logic        pre_buf_zero;
  logic        irq;
  logic [15:0] slips_seen;
  logic [15:0] base;
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;
  int          m;

  pgs_sequencer pgs_sequencer_inst (
    .CLOCK(clock), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYNC_PIN(sync_pin), .DIV_ENABLE(div_enable), .DIV_RESET(div_reset), .DIV_RUN(div_run),
    .DIV_SLIP(div_slip), .BUF_ENABLE(buf_enable), .PRE_BUF_ZERO(pre_buf_zero), .IRQ(irq)
  );

  pgs_far_model pgs_far_model_inst (
    .clk(clock), .srst(srst), .div_slip(div_slip), .sync_req(sync_req),
    .sync_pin(sync_pin), .slips_seen(slips_seen)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    // Only the bench timeout ends this wait
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_wait", k, 32'h2);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic nwait(input int c);
    repeat (c) @(negedge clock);
  endtask

  task automatic t_regs();
    chk("irq_reset", {31'h0, irq}, 32'h0);
    rdx(pgs_pkg::CTRL_OFS, {23'h0, pgs_pkg::CTRL_RST}, "ctrl_rst");
    rdx(pgs_pkg::TIMER_OFS, {20'h0, pgs_pkg::TIMER_RST}, "timer_rst");
    rdx(pgs_pkg::SLIP_COUNT_OFS, {20'h0, pgs_pkg::SLIP_CNT_RST}, "slip_rst");
    rdx(pgs_pkg::DIV_RATIO_OFS, {20'h0, pgs_pkg::DIV_RATIO_RST}, "ratio_rst");
    rdx(pgs_pkg::BURST_OFS, {24'h0, pgs_pkg::BURST_RST}, "burst_rst");
    apb(1'b1, pgs_pkg::TIMER_OFS, 32'hffff_fabc);
    rdx(pgs_pkg::TIMER_OFS, 32'h0000_0abc, "timer_width");
    rdx(pgs_pkg::COMMAND_OFS, 32'h0, "command_read");
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
  endtask

  task automatic t_static();
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_0001);
    nwait(3);
    chk("buf_chan_on", {31'h0, buf_enable}, 32'h1);
    chk("float_idle", {31'h0, pre_buf_zero}, 32'h0);
    // Pulse mode with gate off must still follow the channel enable
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_0181);
    nwait(3);
    chk("buf_gate_off", {31'h0, buf_enable}, 32'h1);
    chk("div_dyn_off", {31'h0, div_enable}, 32'h0);
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_0000);
    nwait(3);
    chk("buf_chan_off", {31'h0, buf_enable}, 32'h0);
  endtask

  task automatic t_slip();
    apb(1'b1, pgs_pkg::SLIP_COUNT_OFS, 32'h0000_0005);
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_0030);
    base = slips_seen;
    apb(1'b1, pgs_pkg::COMMAND_OFS, 32'h0000_0004);
    apb(1'b0, pgs_pkg::STATUS_OFS, 32'h0);
    chk("slip_busy", {31'h0, rd[7]}, 32'h1);
    nwait(40);
    chk("slip_repeat", {16'h0, slips_seen - base}, 32'h5);
    rdx(pgs_pkg::STATUS_OFS, 32'h0000_0001, "slip_idle");
    rdx(pgs_pkg::IRQ_STATUS_OFS, 32'h0000_0001, "slip_alarm");
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, pgs_pkg::IRQ_MASK_OFS, 32'h0000_0003);
    nwait(2);
    chk("irq_unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, pgs_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
    nwait(2);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_0020);
    base = slips_seen;
    apb(1'b1, pgs_pkg::COMMAND_OFS, 32'h0000_0004);
    nwait(20);
    chk("slip_single", {16'h0, slips_seen - base}, 32'h1);
    apb(1'b1, pgs_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
  endtask

  task automatic t_pulse();
    apb(1'b1, pgs_pkg::TIMER_OFS, 32'h0000_0004);
    apb(1'b1, pgs_pkg::BURST_OFS, 32'h0000_0002);
    apb(1'b1, pgs_pkg::SLIP_COUNT_OFS, 32'h0000_0003);
    apb(1'b1, pgs_pkg::DIV_RATIO_OFS, 32'h0000_0020);
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_01bb);
    nwait(3);
    chk("buf_idle", {31'h0, buf_enable}, 32'h0);
    chk("div_idle", {31'h0, div_enable}, 32'h0);
    chk("clamp_idle", {31'h0, pre_buf_zero}, 32'h1);
    base = slips_seen;
    apb(1'b1, pgs_pkg::COMMAND_OFS, 32'h0000_0002);
    for (n = 0; n < 200 && div_enable !== 1'b1; n++) @(negedge clock);
    chk("buf_with_div", {31'h0, buf_enable}, 32'h1);
    chk("clamp_enable", {31'h0, pre_buf_zero}, 32'h1);
    for (n = 0; n < 200 && div_reset !== 1'b1; n++) @(negedge clock);
    chk("en_in_reset", {31'h0, div_enable}, 32'h1);
    for (n = 0; n < 200 && div_reset === 1'b1; n++) @(negedge clock);
    for (n = 0; n < 50 && div_run !== 1'b1; n++) @(negedge clock);
    chk("start_delay", n, pgs_pkg::START_DELAY_CYC);
    chk("clamp_run", {31'h0, pre_buf_zero}, 32'h0);
    for (m = 0; m < 100 && div_run === 1'b1; m++) @(negedge clock);
    chk("run_ticks", {31'h0, m >= 5 && m <= 8}, 32'h1);
    chk("stop_zero", {31'h0, pre_buf_zero}, 32'h1);
    for (n = 0; n < 200 && div_enable === 1'b1; n++) @(negedge clock);
    chk("buf_after", {31'h0, buf_enable}, 32'h0);
    nwait(20);
    chk("auto_slips", {16'h0, slips_seen - base}, 32'h3);
    rdx(pgs_pkg::IRQ_STATUS_OFS, 32'h0000_0003, "seq_alarms");
    chk("irq_seq", {31'h0, irq}, 32'h1);
    apb(1'b1, pgs_pkg::IRQ_STATUS_OFS, 32'h0000_0003);
  endtask

  task automatic t_sync();
    apb(1'b1, pgs_pkg::DIV_RATIO_OFS, 32'h0000_001f);
    apb(1'b1, pgs_pkg::CTRL_OFS, 32'h0000_01cb);
    nwait(3);
    chk("div_small_ratio", {31'h0, div_enable}, 32'h1);
    chk("buf_small_ratio", {31'h0, buf_enable}, 32'h1);
    base = slips_seen;
    @(posedge clock);
    sync_req <= 1'b1;
    @(posedge clock);
    sync_req <= 1'b0;
    for (n = 0; n < 200 && div_run !== 1'b1; n++) @(negedge clock);
    chk("sync_run", {31'h0, div_run}, 32'h1);
    for (m = 0; m < 100 && div_run === 1'b1; m++) @(negedge clock);
    chk("sync_ticks", {31'h0, m >= 1 && m <= 4}, 32'h1);
    nwait(20);
    chk("no_slips", {16'h0, slips_seen - base}, 32'h0);
    rdx(pgs_pkg::STATUS_OFS, 32'h0000_0001, "sync_idle");
    rdx(pgs_pkg::IRQ_STATUS_OFS, 32'h0000_0002, "sync_alarm");
    apb(1'b1, pgs_pkg::COMMAND_OFS, 32'h0000_0001);
    for (n = 0; n < 200 && div_run !== 1'b1; n++) @(negedge clock);
    chk("cmd_sync_run", {31'h0, div_run}, 32'h1);
  endtask

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sync_req = 1'b0;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    t_regs();
    t_static();
    t_slip();
    t_pulse();
    t_sync();
    print_verdict();
  end

  // Whole run needs a few hundred cycles; this only cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
endmodule
